/* File: hw/pmb_pkg.sv */
// shared constants and types of the pci master back-end port
package pmb_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS      = 100;
  // clocks the core waits for a target to claim the address
  localparam int unsigned DEVSEL_WAIT_CLOCKS = 5;
  localparam int unsigned DSEL_CNT_W         = 3;
  localparam int unsigned LAT_W              = 8;

  // ----------------------------------------------------------------
  // pci bus commands and byte enables
  // ----------------------------------------------------------------
  localparam logic [3:0] CMD_MEM_READ      = 4'h6;
  localparam logic [3:0] CMD_MEM_READ_LINE = 4'hE;
  localparam logic [3:0] CMD_MEM_READ_MULT = 4'hC;
  localparam logic [3:0] CMD_MEM_WRITE     = 4'h7;
  localparam logic [3:0] BE_ALL_LANES_N    = 4'h0;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [31:0]      WORD_RST = 32'h0000_0000;
  localparam logic [3:0]       CBE_RST  = 4'h0;
  localparam logic [LAT_W-1:0] LAT_RST  = 8'h00;
  localparam logic [DSEL_CNT_W-1:0] DSEL_RST = 3'h0;

  // ----------------------------------------------------------------
  // master sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [5:0] {
    ST_IDLE = 6'b00_0001,
    ST_REQ  = 6'b00_0010,
    ST_ADDR = 6'b00_0100,
    ST_DATA = 6'b00_1000,
    ST_TURN = 6'b01_0000,
    ST_DONE = 6'b10_0000
  } pmb_state_e;

endpackage : pmb_pkg

/* File: hw/pmb_lat_timer.sv */
// latency timer of the pci master: counts down the granted tenure
module pmb_lat_timer #(
  parameter int unsigned LAT_W = pmb_pkg::LAT_W
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // control
  input  wire logic             load,
  input  wire logic [LAT_W-1:0] load_value,
  // status
  output logic                  expired
);

  logic [LAT_W-1:0] count_ff;
  logic [LAT_W-1:0] nxt_count;
  logic             expired_ff;
  logic             nxt_expired;

  // ----------------------------------------------------------------
  // countdown
  // ----------------------------------------------------------------
  always_comb begin
    nxt_count   = count_ff;
    nxt_expired = expired_ff;
    if (load) begin
      nxt_count   = load_value;
      nxt_expired = 1'b0;
    end else if (count_ff != '0) begin
      nxt_count   = count_ff - LAT_W'(1);
      nxt_expired = (count_ff == LAT_W'(1));
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      count_ff   <= pmb_pkg::LAT_RST;
      expired_ff <= 1'b0;
    end else begin
      count_ff   <= nxt_count;
      expired_ff <= nxt_expired;
    end
  end

  assign expired = expired_ff;

endmodule // pmb_lat_timer

/* File: hw/pmb_core.sv */
// pci master core with its back-end port towards a local dma controller
// ------------------------------------------------------------------
// What this block does
// - port names with _n at the end or before _i/_o are active low, all others active high
// - write words come with a valid; core pops each with a taken strobe
// - write finished is signalled once the write pipeline has drained
// - read words come with one valid strobe each, used as fifo push
// - read finished is signalled once the read pipeline has drained
// - read select 00/01 memory read, 10 read line, 11 read multiple
// - latency enable low ignores the latency timer; keep it high
// - a flag follows each completed data transfer by one clock
// - last-cycle flag marks the final data transfer of a burst
// - copies of own bus request and initiator ready go to the back-end
// - target abort during a master transaction is flagged as error
// - target timeout with no responding target is flagged as error
// - the master never inserts wait states; one word per transfer clock
// ------------------------------------------------------------------
module pmb_core #(
  parameter int unsigned DEVSEL_LIMIT = pmb_pkg::DEVSEL_WAIT_CLOCKS
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // dma request side
  input  wire logic [31:0] master_write_address,
  input  wire logic [31:0] master_read_address,
  input  wire logic        dma_write_phase,
  input  wire logic        dma_read_phase,
  input  wire logic        burst_request,
  input  wire logic        one_remaining,
  input  wire logic        two_or_fewer_remaining,
  input  wire logic [1:0]  read_command_select,
  input  wire logic        latency_limit_enable,
  input  wire logic [7:0]  latency_timer_value,
  // outbound data
  input  wire logic [31:0] outbound_word,
  input  wire logic        outbound_word_valid,
  output logic             outbound_word_taken,
  output logic             write_burst_finished,
  // inbound data
  output logic [31:0]      inbound_word,
  output logic             inbound_word_valid,
  output logic             read_burst_finished,
  // transfer status
  output logic             transfer_seen_prev_clock,
  output logic             last_cycle_flag,
  output logic             bus_request_copy_n,
  output logic             initiator_ready_copy_n,
  output logic             target_abort_seen,
  output logic             target_timeout_seen,
  // pci bus
  output logic             pci_req_n,
  input  wire logic        pci_gnt_n,
  input  wire logic        pci_frame_n_i,
  output logic             pci_frame_n_o,
  output logic             pci_frame_oe,
  input  wire logic        pci_irdy_n_i,
  output logic             pci_irdy_n_o,
  output logic             pci_irdy_oe,
  input  wire logic        pci_trdy_n_i,
  input  wire logic        pci_devsel_n_i,
  input  wire logic        pci_stop_n_i,
  input  wire logic [31:0] pci_ad_i,
  output logic [31:0]      pci_ad_o,
  output logic             pci_ad_oe,
  output logic [3:0]       pci_cbe_n_o,
  output logic             pci_cbe_oe
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [3:0] read_cmd(input logic [1:0] sel);
    unique case (sel)
      2'b10:   read_cmd = pmb_pkg::CMD_MEM_READ_LINE;
      2'b11:   read_cmd = pmb_pkg::CMD_MEM_READ_MULT;
      default: read_cmd = pmb_pkg::CMD_MEM_READ;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  pmb_pkg::pmb_state_e state_ff, nxt_state;
  logic        is_write_ff, nxt_is_write;
  logic        req_n_ff, nxt_req_n;
  logic        frame_n_ff, nxt_frame_n;
  logic        frame_oe_ff, nxt_frame_oe;
  logic        irdy_n_ff, nxt_irdy_n;
  logic        irdy_oe_ff, nxt_irdy_oe;
  logic [31:0] ad_o_ff, nxt_ad_o;
  logic        ad_oe_ff, nxt_ad_oe;
  logic [3:0]  cbe_ff, nxt_cbe;
  logic        cbe_oe_ff, nxt_cbe_oe;
  logic        taken_ff, nxt_taken;
  logic        wr_done_ff, nxt_wr_done;
  logic        rd_done_ff, nxt_rd_done;
  logic [31:0] in_word_ff, nxt_in_word;
  logic        in_valid_ff, nxt_in_valid;
  logic        xfer_d1_ff, nxt_xfer_d1;
  logic        last_ff, nxt_last;
  logic        abort_ff, nxt_abort;
  logic        tto_ff, nxt_tto;
  logic        finished_ff, nxt_finished;
  logic        devsel_seen_ff, nxt_devsel_seen;
  logic [pmb_pkg::DSEL_CNT_W-1:0] dsel_cnt_ff, nxt_dsel_cnt;

  logic xfer, tgt_stop, tgt_abort, tgt_timeout;
  logic lat_expired, tenure_over, bus_idle, phase_req;

  // ----------------------------------------------------------------
  // bus events
  // ----------------------------------------------------------------
  assign xfer        = (state_ff == pmb_pkg::ST_DATA) && !irdy_n_ff
                       && !pci_trdy_n_i && !pci_devsel_n_i;
  assign tgt_stop    = (state_ff == pmb_pkg::ST_DATA) && !pci_stop_n_i && !pci_devsel_n_i;
  assign tgt_abort   = (state_ff == pmb_pkg::ST_DATA) && devsel_seen_ff
                       && pci_devsel_n_i && !pci_stop_n_i;
  assign tgt_timeout = (state_ff == pmb_pkg::ST_DATA) && !devsel_seen_ff && pci_devsel_n_i
                       && (dsel_cnt_ff == pmb_pkg::DSEL_CNT_W'(DEVSEL_LIMIT));
  // tenure ends only when the arbiter has taken the grant away
  assign tenure_over = latency_limit_enable && lat_expired && pci_gnt_n;
  assign bus_idle    = pci_frame_n_i && pci_irdy_n_i;
  assign phase_req   = (dma_write_phase || dma_read_phase) && burst_request;

  pmb_lat_timer #(
    .LAT_W (pmb_pkg::LAT_W)
  ) u_lat_timer (
    .clk        (clk),
    .rst        (rst),
    .load       (state_ff == pmb_pkg::ST_ADDR),
    .load_value (latency_timer_value),
    .expired    (lat_expired)
  );

  // ----------------------------------------------------------------
  // sequencer next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_state       = state_ff;
    nxt_ad_o        = ad_o_ff;
    nxt_cbe         = cbe_ff;
    nxt_in_word     = in_word_ff;
    nxt_dsel_cnt    = dsel_cnt_ff;
    nxt_devsel_seen = devsel_seen_ff;
    nxt_xfer_d1     = xfer;
    {nxt_is_write, nxt_req_n, nxt_frame_n} = {is_write_ff, req_n_ff, frame_n_ff};
    {nxt_frame_oe, nxt_irdy_n, nxt_irdy_oe} = {frame_oe_ff, irdy_n_ff, irdy_oe_ff};
    {nxt_ad_oe, nxt_cbe_oe, nxt_finished} = {ad_oe_ff, cbe_oe_ff, finished_ff};
    {nxt_taken, nxt_wr_done, nxt_rd_done, nxt_in_valid} = 4'h0;
    {nxt_last, nxt_abort, nxt_tto} = 3'h0;

    // read words are pushed one clock after they cross the bus
    if (xfer && !is_write_ff) begin
      nxt_in_word  = pci_ad_i;
      nxt_in_valid = 1'b1;
    end

    unique case (state_ff)
      pmb_pkg::ST_IDLE: begin
        nxt_finished = 1'b0;
        if (phase_req) begin
          nxt_is_write = dma_write_phase;
          nxt_req_n    = 1'b0;
          nxt_state    = pmb_pkg::ST_REQ;
        end
      end
      pmb_pkg::ST_REQ: begin
        if (!phase_req) begin
          nxt_req_n = 1'b1;
          nxt_state = pmb_pkg::ST_IDLE;
        end else if (!pci_gnt_n && bus_idle) begin
          nxt_frame_n  = 1'b0;
          nxt_frame_oe = 1'b1;
          nxt_irdy_n   = 1'b1;
          nxt_irdy_oe  = 1'b1;
          nxt_ad_o     = is_write_ff ? master_write_address : master_read_address;
          nxt_ad_oe    = 1'b1;
          nxt_cbe      = is_write_ff ? pmb_pkg::CMD_MEM_WRITE
                                     : read_cmd(read_command_select);
          nxt_cbe_oe   = 1'b1;
          nxt_devsel_seen = 1'b0;
          nxt_dsel_cnt = pmb_pkg::DSEL_RST;
          nxt_state    = pmb_pkg::ST_ADDR;
        end
      end
      pmb_pkg::ST_ADDR: begin
        nxt_irdy_n = 1'b0;
        nxt_cbe    = pmb_pkg::BE_ALL_LANES_N;
        nxt_ad_oe  = is_write_ff;
        if (is_write_ff) begin
          nxt_ad_o  = outbound_word;
          nxt_taken = outbound_word_valid;
        end
        // a single-word burst starts straight in its final phase
        if (one_remaining) begin
          nxt_frame_n = 1'b1;
          nxt_req_n   = 1'b1;
          nxt_last    = 1'b1;
        end
        nxt_state = pmb_pkg::ST_DATA;
      end
      pmb_pkg::ST_DATA: begin
        if (!pci_devsel_n_i) begin
          nxt_devsel_seen = 1'b1;
        end else if (!devsel_seen_ff) begin
          nxt_dsel_cnt = dsel_cnt_ff + pmb_pkg::DSEL_CNT_W'(1);
        end
        if (tgt_abort || tgt_timeout) begin
          nxt_abort    = tgt_abort;
          nxt_tto      = tgt_timeout;
          nxt_finished = 1'b1;
          nxt_frame_n  = 1'b1;
          nxt_frame_oe = 1'b0;
          nxt_irdy_n   = 1'b1;
          nxt_ad_oe    = 1'b0;
          nxt_cbe_oe   = 1'b0;
          nxt_req_n    = 1'b1;
          nxt_state    = pmb_pkg::ST_TURN;
        end else if (frame_n_ff) begin
          // final phase: the burst is done on a transfer with the last flag set, cut short on a stop or without it
          if (xfer || tgt_stop) begin
            nxt_finished = xfer && last_ff;
            nxt_frame_oe = 1'b0;
            nxt_irdy_n   = 1'b1;
            nxt_ad_oe    = 1'b0;
            nxt_cbe_oe   = 1'b0;
            nxt_state    = pmb_pkg::ST_TURN;
          end else begin
            nxt_last = last_ff;
          end
        end else if (xfer || tgt_stop) begin
          if (xfer && is_write_ff) begin
            nxt_ad_o  = outbound_word;
            nxt_taken = outbound_word_valid;
          end
          if (tgt_stop || tenure_over || (xfer && two_or_fewer_remaining)) begin
            nxt_frame_n = 1'b1;
            nxt_req_n   = 1'b1;
            nxt_last    = !tgt_stop && xfer && two_or_fewer_remaining;
          end
        end
      end
      pmb_pkg::ST_TURN: begin
        nxt_irdy_oe = 1'b0;
        nxt_req_n   = 1'b1;
        nxt_state   = pmb_pkg::ST_DONE;
      end
      pmb_pkg::ST_DONE: begin
        // the last read word was pushed in the previous clock: pipeline empty
        if (finished_ff) begin
          nxt_wr_done = is_write_ff;
          nxt_rd_done = !is_write_ff;
          nxt_state   = pmb_pkg::ST_IDLE;
        end else if (phase_req) begin
          // cut short: ask again, the dma address has moved on meanwhile
          nxt_req_n = 1'b0;
          nxt_state = pmb_pkg::ST_REQ;
        end else begin
          nxt_state = pmb_pkg::ST_IDLE;
        end
      end
    endcase
  end

  // ----------------------------------------------------------------
  // sequencer registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      state_ff    <= pmb_pkg::ST_IDLE;
      ad_o_ff     <= pmb_pkg::WORD_RST;
      cbe_ff      <= pmb_pkg::CBE_RST;
      in_word_ff  <= pmb_pkg::WORD_RST;
      dsel_cnt_ff <= pmb_pkg::DSEL_RST;
      {req_n_ff, frame_n_ff, irdy_n_ff} <= 3'h7;
      {taken_ff, wr_done_ff, rd_done_ff, in_valid_ff, xfer_d1_ff, last_ff} <= 6'h00;
      {abort_ff, tto_ff, finished_ff, is_write_ff, frame_oe_ff, irdy_oe_ff} <= 6'h00;
      {ad_oe_ff, cbe_oe_ff, devsel_seen_ff} <= 3'h0;
    end else begin
      state_ff    <= nxt_state;
      ad_o_ff     <= nxt_ad_o;
      cbe_ff      <= nxt_cbe;
      in_word_ff  <= nxt_in_word;
      dsel_cnt_ff <= nxt_dsel_cnt;
      {req_n_ff, frame_n_ff, irdy_n_ff} <= {nxt_req_n, nxt_frame_n, nxt_irdy_n};
      {taken_ff, wr_done_ff, rd_done_ff} <= {nxt_taken, nxt_wr_done, nxt_rd_done};
      {in_valid_ff, xfer_d1_ff, last_ff} <= {nxt_in_valid, nxt_xfer_d1, nxt_last};
      {abort_ff, tto_ff, finished_ff} <= {nxt_abort, nxt_tto, nxt_finished};
      {is_write_ff, frame_oe_ff, irdy_oe_ff} <= {nxt_is_write, nxt_frame_oe, nxt_irdy_oe};
      {ad_oe_ff, cbe_oe_ff, devsel_seen_ff} <= {nxt_ad_oe, nxt_cbe_oe, nxt_devsel_seen};
    end
  end

  // ----------------------------------------------------------------
  // outputs, all straight from registers
  // ----------------------------------------------------------------
  assign outbound_word_taken      = taken_ff;
  assign write_burst_finished     = wr_done_ff;
  assign inbound_word             = in_word_ff;
  assign inbound_word_valid       = in_valid_ff;
  assign read_burst_finished      = rd_done_ff;
  assign transfer_seen_prev_clock = xfer_d1_ff;
  assign last_cycle_flag          = last_ff;
  assign bus_request_copy_n       = req_n_ff;
  assign initiator_ready_copy_n   = irdy_n_ff;
  assign target_abort_seen        = abort_ff;
  assign target_timeout_seen      = tto_ff;
  assign pci_req_n                = req_n_ff;
  assign pci_frame_n_o            = frame_n_ff;
  assign pci_frame_oe             = frame_oe_ff;
  assign pci_irdy_n_o             = irdy_n_ff;
  assign pci_irdy_oe              = irdy_oe_ff;
  assign pci_ad_o                 = ad_o_ff;
  assign pci_ad_oe                = ad_oe_ff;
  assign pci_cbe_n_o              = cbe_ff;
  assign pci_cbe_oe               = cbe_oe_ff;

endmodule // pmb_core

/* File: verif/pmb_core_chk.sv */
// concurrent checks on the ports of the pci master back-end core
module pmb_core_chk #(
  parameter int unsigned DEVSEL_LIMIT = pmb_pkg::DEVSEL_WAIT_CLOCKS
) (
  // clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // back-end port
  input wire logic        outbound_word_valid,
  input wire logic        outbound_word_taken,
  input wire logic        write_burst_finished,
  input wire logic [31:0] inbound_word,
  input wire logic        inbound_word_valid,
  input wire logic        read_burst_finished,
  input wire logic        transfer_seen_prev_clock,
  input wire logic        last_cycle_flag,
  input wire logic        bus_request_copy_n,
  input wire logic        initiator_ready_copy_n,
  input wire logic        target_abort_seen,
  input wire logic        target_timeout_seen,
  // pci bus
  input wire logic        pci_req_n,
  input wire logic        pci_frame_n_o,
  input wire logic        pci_frame_oe,
  input wire logic        pci_irdy_n_o,
  input wire logic        pci_irdy_oe,
  input wire logic        pci_trdy_n_i,
  input wire logic        pci_devsel_n_i,
  input wire logic        pci_stop_n_i,
  input wire logic [31:0] pci_ad_i,
  input wire logic        pci_ad_oe
);
  // --------
  // helpers
  // --------
  timeunit 1ns;
  timeprecision 1ns;
  logic xfer;
  assign xfer = pci_irdy_oe && !pci_irdy_n_o && !pci_trdy_n_i && !pci_devsel_n_i;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  sequence s_released;
    !pci_frame_oe && !pci_irdy_oe && !pci_ad_oe;
  endsequence
  sequence s_final;
    xfer && last_cycle_flag;
  endsequence
  // a claimed, unstopped data phase with frame still low is never paused
  sequence s_mid_burst;
    pci_irdy_oe && !pci_irdy_n_o && !pci_frame_n_o && !pci_devsel_n_i && pci_stop_n_i;
  endsequence
  // --------
  // properties
  // --------
  property p_pop;
    outbound_word_taken |-> $past(outbound_word_valid);
  endproperty
  a_pop: assert property (p_pop) else $error("pop without valid word");
  property p_push;
    inbound_word_valid |-> $past(xfer) && inbound_word == $past(pci_ad_i);
  endproperty
  a_push: assert property (p_push) else $error("push not after transfer");
  property p_moved;
    xfer |=> transfer_seen_prev_clock;
  endproperty
  a_moved: assert property (p_moved) else $error("transfer flag missing");
  property p_moved_cause;
    transfer_seen_prev_clock |-> $past(xfer);
  endproperty
  a_moved_cause: assert property (p_moved_cause) else $error("transfer flag spurious");
  property p_final;
    s_final |-> !pci_frame_oe || pci_frame_n_o;
  endproperty
  a_final: assert property (p_final) else $error("last flag while frame held");
  property p_wr_done;
    write_burst_finished |-> s_released ##1 !write_burst_finished;
  endproperty
  a_wr_done: assert property (p_wr_done) else $error("write finished early");
  property p_rd_done;
    read_burst_finished |-> s_released ##0 !inbound_word_valid ##1 !read_burst_finished;
  endproperty
  a_rd_done: assert property (p_rd_done) else $error("read finished early");
  property p_copies;
    bus_request_copy_n == pci_req_n && initiator_ready_copy_n == pci_irdy_n_o;
  endproperty
  a_copies: assert property (p_copies) else $error("request copies differ");
  property p_abort;
    target_abort_seen |-> $past(!pci_stop_n_i && pci_devsel_n_i)
      || $past(!pci_stop_n_i && pci_devsel_n_i, 2);
  endproperty
  a_abort: assert property (p_abort) else $error("abort without stop");
  property p_timeout;
    target_timeout_seen |-> $past(pci_devsel_n_i) && $past(pci_devsel_n_i, 2);
  endproperty
  a_timeout: assert property (p_timeout) else $error("timeout with claim");
  property p_no_wait;
    s_mid_burst |=> pci_irdy_oe && !pci_irdy_n_o;
  endproperty
  a_no_wait: assert property (p_no_wait) else $error("master wait state");
endmodule // pmb_core_chk

bind pmb_core pmb_core_chk #(.DEVSEL_LIMIT(DEVSEL_LIMIT)) i_pmb_core_chk (.*);

/* File: verif/pmb_dma_model.sv */
// behavioural dma controller with always-ready fifos facing the back-end port
module pmb_dma_model (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // burst order from the bench
  input  wire logic        go,
  input  wire logic        go_write,
  input  wire logic [7:0]  go_words,
  input  wire logic [31:0] go_base,
  // request side of the core
  output logic [31:0]      master_write_address,
  output logic [31:0]      master_read_address,
  output logic             dma_write_phase,
  output logic             dma_read_phase,
  output logic             burst_request,
  output logic             one_remaining,
  output logic             two_or_fewer_remaining,
  // outbound fifo
  output logic [31:0]      outbound_word,
  output logic             outbound_word_valid,
  input  wire logic        outbound_word_taken,
  // completion and progress
  input  wire logic        write_burst_finished,
  input  wire logic        read_burst_finished,
  input  wire logic        transfer_seen_prev_clock
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0]  words_ff, left_ff, popped_ff, left_now, pop_now;
  logic [31:0] base_ff, addr_now;
  logic        wr_ff, act_ff;
  // the flag lags the bus by a clock, so the word moving now still counts
  assign left_now = left_ff - {7'h00, transfer_seen_prev_clock};
  assign pop_now  = popped_ff + {7'h00, outbound_word_taken};
  assign addr_now = base_ff + {22'h0, words_ff - left_now, 2'b00};
  // an unused address shows its inverse so a stale sample is caught
  assign master_write_address   = (act_ff && wr_ff) ? addr_now : ~addr_now;
  assign master_read_address    = (act_ff && !wr_ff) ? addr_now : ~addr_now;
  assign dma_write_phase        = act_ff && wr_ff;
  assign dma_read_phase         = act_ff && !wr_ff;
  assign burst_request          = act_ff && !write_burst_finished && !read_burst_finished;
  assign one_remaining          = act_ff && left_now == 8'h01;
  assign two_or_fewer_remaining = act_ff && left_now <= 8'h02;
  // fifo shows the next word in the clock of the pop: no wait state needed
  assign outbound_word          = base_ff ^ {4{pop_now}};
  assign outbound_word_valid    = act_ff && wr_ff;
  always_ff @(posedge clk) begin
    if (rst) begin
      act_ff <= 1'b0;
      wr_ff <= 1'b0;
      base_ff <= 32'h0000_0000;
      words_ff <= 8'h00;
      left_ff <= 8'h00;
      popped_ff <= 8'h00;
    end else if (go) begin
      act_ff <= 1'b1;
      wr_ff <= go_write;
      base_ff <= go_base;
      words_ff <= go_words;
      left_ff <= go_words;
      popped_ff <= 8'h00;
    end else begin
      if (write_burst_finished || read_burst_finished) begin
        act_ff <= 1'b0;
      end
      left_ff <= left_now;
      popped_ff <= pop_now;
    end
  end
endmodule // pmb_dma_model

/* File: verif/pmb_core_tb.sv */
// self-checking bench of the pci master back-end core
module pmb_core_tb;
  timeunit 1ns;
  timeprecision 1ns;
  // --------
  // signals
  // --------
  logic        clk = 1'b0, rst = 1'b1, go = 1'b0, go_write = 1'b0;
  logic [7:0]  go_words = 8'h01, latency_timer_value = 8'h02;
  logic [31:0] go_base = 32'h0000_0000, pci_ad_i = 32'h0000_0000;
  logic [31:0] master_write_address, master_read_address, outbound_word, inbound_word, pci_ad_o;
  logic        dma_write_phase, dma_read_phase, burst_request, one_remaining;
  logic        two_or_fewer_remaining, outbound_word_valid, outbound_word_taken;
  logic        write_burst_finished, inbound_word_valid, read_burst_finished;
  logic        transfer_seen_prev_clock, last_cycle_flag, bus_request_copy_n;
  logic        initiator_ready_copy_n, target_abort_seen, target_timeout_seen, pci_req_n;
  logic        pci_frame_n_o, pci_frame_oe, pci_irdy_n_o, pci_irdy_oe, pci_ad_oe, pci_cbe_oe;
  logic        pci_frame_n_i, pci_irdy_n_i, gnt_drop = 1'b0, latency_limit_enable = 1'b1;
  logic        pci_gnt_n = 1'b0, pci_trdy_n_i = 1'b1, pci_devsel_n_i = 1'b1, pci_stop_n_i = 1'b1;
  logic [3:0]  pci_cbe_n_o;
  logic [1:0]  read_command_select = 2'h0, mode = 2'h0;
  int          err_count = 0, n_tests = 0;
  int          n_addr, n_done, n_push, n_seen, n_last, n_wf, n_rf, n_ab, n_to;
  // released pins float high through the bus pull-ups
  assign pci_frame_n_i = pci_frame_oe ? pci_frame_n_o : 1'b1;
  assign pci_irdy_n_i  = pci_irdy_oe ? pci_irdy_n_o : 1'b1;
  pmb_core #(.DEVSEL_LIMIT(2)) i_pmb_core (.*);
  pmb_dma_model i_pmb_dma_model (.*);
  initial forever #50 clk = ~clk;
  function automatic logic [31:0] wdata(logic [31:0] b, int k);
    return b ^ {4{k[7:0]}};
  endfunction
  function automatic logic [31:0] rdata(logic [31:0] b, int k);
    return ~b ^ {4{k[7:0]}};
  endfunction
  function automatic logic [3:0] cmd_of(logic w, logic [1:0] s);
    if (w) return pmb_pkg::CMD_MEM_WRITE;
    return s == 2'h3 ? pmb_pkg::CMD_MEM_READ_MULT
         : s == 2'h2 ? pmb_pkg::CMD_MEM_READ_LINE : pmb_pkg::CMD_MEM_READ;
  endfunction
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic end_sim();
    if (err_count == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // --------
  // pci target, arbiter and monitor; mode 0 claims, 1 aborts, 2 never answers
  // --------
  always @(posedge clk) begin
    if (!rst) begin
      if (pci_frame_oe && !pci_frame_n_o && pci_irdy_n_o && pci_ad_oe) begin
        n_addr++;
        check("address", go_base + 32'(4 * n_done), pci_ad_o);
        check("command", 32'(cmd_of(go_write, read_command_select)), 32'(pci_cbe_n_o));
        check("command enable", 32'h0000_0001, 32'(pci_cbe_oe));
      end
      if (!pci_irdy_n_i && !pci_trdy_n_i && !pci_devsel_n_i) begin
        if (go_write) check("write word", wdata(go_base, n_done), pci_ad_o);
        if (last_cycle_flag === 1'b1) n_last++;
        n_done++;
        pci_ad_i <= rdata(go_base, n_done);
      end
      if (inbound_word_valid === 1'b1) begin
        check("read word", rdata(go_base, n_push), inbound_word);
        n_push++;
      end
      n_seen += int'(transfer_seen_prev_clock === 1'b1);
      n_wf += int'(write_burst_finished === 1'b1);
      n_rf += int'(read_burst_finished === 1'b1);
      n_ab += int'(target_abort_seen === 1'b1);
      n_to += int'(target_timeout_seen === 1'b1);
    end
    if (pci_frame_n_i && pci_irdy_n_i) {pci_devsel_n_i, pci_trdy_n_i, pci_stop_n_i} <= 3'b111;
    else if (mode == 2'h0) {pci_devsel_n_i, pci_trdy_n_i, pci_stop_n_i} <= 3'b001;
    else if (mode == 2'h1) begin
      {pci_devsel_n_i, pci_trdy_n_i, pci_stop_n_i} <=
        (pci_devsel_n_i && pci_stop_n_i) ? 3'b011 : 3'b110;
    end
    pci_gnt_n <= gnt_drop && !pci_frame_n_i;
  end
  // --------
  // one burst ordered through the dma model and judged at its end
  // --------
  task automatic burst(input logic wr, input int nw, input logic [1:0] md, input logic drop,
                       input logic len, input logic [1:0] cmd);
    logic [31:0] b;
    int i;
    b = $urandom & 32'hffff_fffc;
    {n_addr, n_done, n_push, n_seen, n_last, n_wf, n_rf, n_ab, n_to} = '0;
    go_write <= wr;
    go_words <= 8'(nw);
    go_base <= b;
    mode <= md;
    gnt_drop <= drop;
    latency_limit_enable <= len;
    read_command_select <= cmd;
    pci_ad_i <= rdata(b, 0);
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    for (i = 0; i < 600 && n_wf + n_rf == 0; i++) @(posedge clk);
    if (i == 600) begin
      check("burst finished", 32'h0000_0001, 32'h0000_0000);
      end_sim();
    end
    repeat (3) @(posedge clk);
    check("write finished", 32'(wr), n_wf);
    check("read finished", 32'(!wr), n_rf);
    check("abort flag", 32'(md == 2'h1), n_ab);
    check("timeout flag", 32'(md == 2'h2), n_to);
    if (md == 2'h0) begin
      check("words moved", nw, n_done);
      check("transfer flags", n_done, n_seen);
      check("last flags", 32'h0000_0001, n_last);
      check("pushes", wr ? 0 : nw, n_push);
      check("tenures", 32'(drop && len), 32'(n_addr > 1));
    end
  endtask
  initial begin
    int k;
    void'($urandom(32'hbe8c9e08));
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    check("idle after reset", 32'h0000_0001, 32'(pci_req_n && !pci_frame_oe));
    burst(1'b1, 1, 2'h0, 1'b0, 1'b1, 2'h0);
    burst(1'b0, 1, 2'h0, 1'b0, 1'b1, 2'h1);
    burst(1'b0, 2, 2'h0, 1'b0, 1'b0, 2'h2);
    for (k = 0; k < 12; k++) begin
      burst(k[0], 1 + int'($urandom % 6), 2'h0, 1'b0, 1'($urandom), k[2:1]);
    end
    burst(1'b1, 8, 2'h0, 1'b1, 1'b0, 2'h0);
    burst(1'b1, 8, 2'h0, 1'b1, 1'b1, 2'h0);
    burst(1'b0, 8, 2'h0, 1'b1, 1'b1, 2'h3);
    burst(1'b1, 3, 2'h1, 1'b0, 1'b1, 2'h0);
    burst(1'b0, 3, 2'h2, 1'b0, 1'b1, 2'h0);
    end_sim();
  end
endmodule // pmb_core_tb
